/* File: src/security_sublayer_encap.sv */
// security sublayer packet path: tx and rx with default stages
// assumes partners on clk_i; an external checker gives auth verdict per rx packet
`timescale 1ns/10ps
`default_nettype none

module sec_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t s_q, s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push, pop;

    assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_q.cnt != '0);
    assign out_data_o = mem_q[s_q.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[s_q.wr] <= in_data_i;
        end
    end
endmodule // sec_fifo

// Overview of operation
// R01 - tx packet with secure flag clear leaves unchanged, no security stage
// R02 - rx packet with secure flag clear delivered upward unchanged
// R03 - every packet carries its secure flag through both directions
// R04 - secured tx: one cryptosync per packet from destination channel, held
// R05 - secured tx: encryption uses cryptosync and key, passes to authentication
// R06 - secured tx: authentication builds packet, security stage forwards to MAC
// R07 - secured rx: cryptosync built from lower MAC channel info first
// R08 - secured rx: strip security header/trailer, pass payload and sync on
// R09 - secured rx: verify signature; failing packets discarded, never decrypted
// R10 - secured rx: decrypt after verify passes, deliver plaintext upward
// R11 - security headers and trailers optional, zero length allowed
// R12 - default cipher leaves payload unchanged, adds no header or trailer
// R13 - default cipher forwards tx to authentication, rx to upper layer
// R14 - default cipher subtype constant reads zero
// R15 - on reset every cipher attribute takes its default value
// R16 - secure mode on at terminal forces secure flag on every tx packet
// R17 - default security stage adds no header and no trailer
// R18 - packets are word streams with valid/ready, sop/eop, flag on first word
module security_sublayer_encap
    import sec_encap_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic secure_mode_on_i,
    input wire logic is_terminal_i,
    input wire sec_encap_pkg::chan_info_t tx_chan_i,
    input wire sec_encap_pkg::chan_info_t rx_chan_i,
    input wire logic auth_pass_valid_i,
    input wire logic auth_pass_i,
    input wire logic up_tx_valid_i,
    output logic up_tx_ready_o,
    input wire sec_encap_pkg::beat_t up_tx_beat_i,
    output logic mac_tx_valid_o,
    input wire logic mac_tx_ready_i,
    output sec_encap_pkg::beat_t mac_tx_beat_o,
    output logic [SYNC_W-1:0] tx_sync_o,
    input wire logic mac_rx_valid_i,
    output logic mac_rx_ready_o,
    input wire sec_encap_pkg::beat_t mac_rx_beat_i,
    output logic up_rx_valid_o,
    input wire logic up_rx_ready_i,
    output sec_encap_pkg::beat_t up_rx_beat_o,
    output logic [SYNC_W-1:0] rx_sync_o,
    output logic rx_drop_o,
    output logic [15:0] cipher_subtype_o
);
    import sec_encap_pkg::*;

    typedef struct packed {
        path_state_t tx_st;
        logic tx_sec;
        logic [SYNC_W-1:0] tx_sync;
        path_state_t rx_st;
        logic rx_sec;
        logic [SYNC_W-1:0] rx_sync;
        logic rx_drop;
        logic mode_on;
    } top_state_t;

    top_state_t s_q, s_d;
    beat_t tx_beat, rx_beat;
    logic tx_fifo_ready, tx_take, rx_take, rx_wait, rx_fifo_ready, rx_push;

    function automatic logic [SYNC_W-1:0] make_sync(input chan_info_t c);
        logic [ATTR_W-1:0] attr;
        attr = '0;
        attr[ATTR_ISFL_BIT] = c.is_fl;
        attr[ATTR_STICKY_BIT] = c.is_sticky;
        return {c.macid, c.pilot_pn, c.connect_count, attr, c.frame_index};
    endfunction

    // default cipher and default security stage are identity on the payload
    function automatic beat_t default_stages(input beat_t b);
        return b; // R12 R17 R11
    endfunction

    assign cipher_subtype_o = DEFAULT_CIPHER_SUBTYPE_CONST; // R14

    // transmit: up stream into fifo toward the lower MAC
    assign tx_take = up_tx_valid_i && tx_fifo_ready;
    assign up_tx_ready_o = tx_fifo_ready;

    always_comb begin
        tx_beat = up_tx_beat_i;
        if (s_q.mode_on && is_terminal_i) begin
            tx_beat.secure_flag = 1'b1; // R16
        end else if (up_tx_beat_i.sop || s_q.tx_st == ST_IDLE) begin
            tx_beat.secure_flag = up_tx_beat_i.secure_flag; // R18
        end else begin
            tx_beat.secure_flag = s_q.tx_sec; // R03
        end
        if (tx_beat.secure_flag) begin
            // encrypt, authenticate and frame, each default stage unchanged
            tx_beat = default_stages(tx_beat); // R05 R06 R13
        end // else bypass R01
    end

    // receive: verdict gating on the first word, then fifo upward
    assign rx_wait = (s_q.rx_st == ST_IDLE) && mac_rx_beat_i.sop
        && mac_rx_beat_i.secure_flag && !auth_pass_valid_i;
    assign mac_rx_ready_o = !rx_wait && (s_q.rx_st == ST_DROP || rx_fifo_ready
        || (s_q.rx_st == ST_IDLE && mac_rx_beat_i.secure_flag && !auth_pass_i));
    assign rx_take = mac_rx_valid_i && mac_rx_ready_o;

    always_comb begin
        rx_beat = mac_rx_beat_i;
        if (s_q.rx_st != ST_IDLE) begin
            rx_beat.secure_flag = s_q.rx_sec; // R03
        end
        if (rx_beat.secure_flag) begin
            rx_beat = default_stages(rx_beat); // R08 R10 R13
        end // else passthrough R02
    end

    assign rx_push = rx_take && (s_q.rx_st == ST_PASS
        || (s_q.rx_st == ST_IDLE && (!mac_rx_beat_i.secure_flag || auth_pass_i))); // R09

    always_comb begin
        s_d = s_q;
        s_d.rx_drop = 1'b0;
        s_d.mode_on = secure_mode_on_i;
        if (tx_take) begin
            if (s_q.tx_st == ST_IDLE || up_tx_beat_i.sop) begin
                s_d.tx_sec = tx_beat.secure_flag;
                if (tx_beat.secure_flag) begin
                    s_d.tx_sync = make_sync(tx_chan_i); // R04
                end
                s_d.tx_st = up_tx_beat_i.eop ? ST_IDLE : ST_PASS;
            end else if (up_tx_beat_i.eop) begin
                s_d.tx_st = ST_IDLE;
            end
        end
        if (rx_take) begin
            unique case (s_q.rx_st)
                ST_IDLE: begin
                    s_d.rx_sec = mac_rx_beat_i.secure_flag;
                    if (mac_rx_beat_i.secure_flag) begin
                        s_d.rx_sync = make_sync(rx_chan_i); // R07
                    end
                    if (mac_rx_beat_i.secure_flag && !auth_pass_i) begin
                        s_d.rx_drop = 1'b1; // R09
                        s_d.rx_st = mac_rx_beat_i.eop ? ST_IDLE : ST_DROP;
                    end else begin
                        s_d.rx_st = mac_rx_beat_i.eop ? ST_IDLE : ST_PASS;
                    end
                end
                ST_PASS, ST_DROP: begin
                    if (mac_rx_beat_i.eop) begin
                        s_d.rx_st = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.tx_st <= ST_IDLE;
            s_q.tx_sec <= 1'b0;
            s_q.tx_sync <= SYNC_RST;
            s_q.rx_st <= ST_IDLE;
            s_q.rx_sec <= 1'b0;
            s_q.rx_sync <= SYNC_RST;
            s_q.rx_drop <= 1'b0;
            s_q.mode_on <= SECURE_MODE_ON_RST; // R15
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_sync_o = s_q.tx_sync;
    assign rx_sync_o = s_q.rx_sync;
    assign rx_drop_o = s_q.rx_drop;

    sec_fifo #(.WIDTH($bits(beat_t)), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(up_tx_valid_i),
        .in_ready_o(tx_fifo_ready),
        .in_data_i(tx_beat),
        .out_valid_o(mac_tx_valid_o),
        .out_ready_i(mac_tx_ready_i),
        .out_data_o(mac_tx_beat_o)
    );

    sec_fifo #(.WIDTH($bits(beat_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(rx_push),
        .in_ready_o(rx_fifo_ready),
        .in_data_i(rx_beat),
        .out_valid_o(up_rx_valid_o),
        .out_ready_i(up_rx_ready_i),
        .out_data_o(up_rx_beat_o)
    );
endmodule // security_sublayer_encap

`default_nettype wire

/* File: include/sec_encap_pkg.sv */
// shared types and constants of the security sublayer packet path
// assumes one 100 MHz clock and stream partners on the same clock
package sec_encap_pkg;

    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_W = 96;
    localparam int MACID_W = 12;
    localparam int PILOT_W = 12;
    localparam int CONN_W = 16;
    localparam int ATTR_W = 16;
    localparam int FRAME_W = 40;
    localparam int ATTR_ISFL_BIT = 0;
    localparam int ATTR_STICKY_BIT = 1;
    localparam logic [15:0] DEFAULT_CIPHER_SUBTYPE_CONST = 16'h0000;
    localparam logic SECURE_MODE_ON_RST = 1'b0;
    localparam logic [SYNC_W-1:0] SYNC_RST = 96'h0;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic sop;
        logic eop;
        logic secure_flag;
    } beat_t;

    // channel info offered by the lower MAC for cryptosync
    typedef struct packed {
        logic [MACID_W-1:0] macid;
        logic [PILOT_W-1:0] pilot_pn;
        logic [CONN_W-1:0] connect_count;
        logic is_fl;
        logic is_sticky;
        logic [FRAME_W-1:0] frame_index;
    } chan_info_t;

    typedef enum logic [1:0] {ST_IDLE, ST_PASS, ST_DROP} path_state_t;

endpackage

/* File: testbench/sec_encap_properties.sv */
// checker: stream, sync and drop properties of the security path
// assumes it is bound to security_sublayer_encap
`timescale 1ns/10ps
`default_nettype none
module sec_encap_properties
    import sec_encap_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic auth_pass_valid_i,
    input wire logic auth_pass_i,
    input wire logic up_tx_valid_i,
    input wire logic up_tx_ready_o,
    input wire sec_encap_pkg::beat_t up_tx_beat_i,
    input wire logic mac_tx_valid_o,
    input wire logic mac_tx_ready_i,
    input wire sec_encap_pkg::beat_t mac_tx_beat_o,
    input wire logic [SYNC_W-1:0] tx_sync_o,
    input wire logic mac_rx_valid_i,
    input wire logic mac_rx_ready_o,
    input wire sec_encap_pkg::beat_t mac_rx_beat_i,
    input wire logic up_rx_valid_o,
    input wire logic up_rx_ready_i,
    input wire sec_encap_pkg::beat_t up_rx_beat_o,
    input wire logic [SYNC_W-1:0] rx_sync_o,
    input wire logic rx_drop_o,
    input wire logic [15:0] cipher_subtype_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic rx_sec_sop;
    assign rx_sec_sop = mac_rx_valid_i && mac_rx_beat_i.sop && mac_rx_beat_i.secure_flag;
    a_subtype_zero:
        assert property (cipher_subtype_o == 16'h0000) else $error("subtype not zero");
    a_tx_beat_hold:
        assert property (mac_tx_valid_o && !mac_tx_ready_i |=> mac_tx_valid_o
            && $stable(mac_tx_beat_o)) else $error("tx beat not held");
    a_rx_beat_hold:
        assert property (up_rx_valid_o && !up_rx_ready_i |=> up_rx_valid_o
            && $stable(up_rx_beat_o)) else $error("rx beat not held");
    a_tx_empty_ready:
        assert property (!mac_tx_valid_o |-> up_tx_ready_o) else $error("empty fifo refused");
    a_verdict_wait:
        assert property (rx_sec_sop && !auth_pass_valid_i |-> !mac_rx_ready_o)
            else $error("secured word taken without verdict");
    a_drop_cause:
        assert property (rx_drop_o |-> $past(rx_sec_sop && mac_rx_ready_o
            && auth_pass_valid_i && !auth_pass_i)) else $error("drop without failed verdict");
    a_rx_sync_cause:
        assert property ($changed(rx_sync_o) |-> $past(rx_sec_sop && mac_rx_ready_o))
            else $error("rx sync changed without secured first word");
    a_tx_sync_cause:
        assert property ($changed(tx_sync_o) |-> $past(up_tx_valid_i && up_tx_ready_o
            && up_tx_beat_i.sop)) else $error("tx sync changed mid packet");
    c_drop: cover property (rx_drop_o);
    c_tx_stall: cover property (mac_tx_valid_o && !mac_tx_ready_i);
    c_tx_full: cover property (up_tx_valid_i && !up_tx_ready_o);
endmodule // sec_encap_properties
bind security_sublayer_encap sec_encap_properties sec_encap_properties_inst (.*);
`default_nettype wire

/* File: testbench/far_side_model.sv */
// far side model: ready of the lower MAC sink and the upper sink
// assumes the same clock as the block
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic stall_i,
    input wire logic block_i,
    output logic tx_ready_o,
    output logic rx_ready_o
);
    logic tick_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) tick_q <= 1'b0;
        else tick_q <= !tick_q;
    end
    // slow mode takes every other cycle; block holds the mac sink off
    assign tx_ready_o = !block_i && (!stall_i || tick_q);
    assign rx_ready_o = !stall_i || !tick_q;
endmodule // far_side_model
`default_nettype wire

/* File: testbench/tb_security_sublayer_encap.sv */
// testbench of the security sublayer packet path
// assumes far_side_model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module tb_security_sublayer_encap;
    import sec_encap_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic mode = 1'b0, term = 1'b0, apv = 1'b0, ap = 1'b0, stall = 1'b0, block = 1'b0;
    logic utv = 1'b0, mrv = 1'b0, mtr, urr, utr, mtv, mrr, urv, drop;
    beat_t utb = '0, mrb = '0, mtb, urb;
    chan_info_t txc = {12'hA1, 12'h03C, 16'h0102, 1'b1, 1'b0, 40'h123456789A};
    chan_info_t rxc = {12'h05B, 12'h0D7, 16'h0FED, 1'b0, 1'b1, 40'hABCDEF0123};
    logic [SYNC_W-1:0] txs, rxs;
    logic [15:0] sub;
    beat_t tq[$], rq[$];
    int n_errors = 0, comparisons = 0, drops = 0;
    security_sublayer_encap security_sublayer_encap_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .secure_mode_on_i(mode), .is_terminal_i(term), .tx_chan_i(txc), .rx_chan_i(rxc),
        .auth_pass_valid_i(apv), .auth_pass_i(ap), .up_tx_valid_i(utv), .up_tx_ready_o(utr),
        .up_tx_beat_i(utb), .mac_tx_valid_o(mtv), .mac_tx_ready_i(mtr), .mac_tx_beat_o(mtb),
        .tx_sync_o(txs), .mac_rx_valid_i(mrv), .mac_rx_ready_o(mrr), .mac_rx_beat_i(mrb),
        .up_rx_valid_o(urv), .up_rx_ready_i(urr), .up_rx_beat_o(urb), .rx_sync_o(rxs),
        .rx_drop_o(drop), .cipher_subtype_o(sub));
    far_side_model far_side_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall),
        .block_i(block), .tx_ready_o(mtr), .rx_ready_o(urr));
    initial forever #5 clk_i = !clk_i;
    always @(posedge clk_i) begin
        if (mtv && mtr) tq.push_back(mtb);
        if (urv && urr) rq.push_back(urb);
        if (drop) drops++;
    end
    function automatic logic [SYNC_W-1:0] sync_of(input chan_info_t c);
        return {c.macid, c.pilot_pn, c.connect_count, 14'h0, c.is_sticky, c.is_fl, c.frame_index};
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input bit rx, input beat_t b);
        int n;
        n = 0;
        @(negedge clk_i);
        if (rx) begin
            mrv = 1'b1;
            mrb = b;
        end else begin
            utv = 1'b1;
            utb = b;
        end
        do begin
            @(posedge clk_i);
            n++;
        end while (!(rx ? mrr : utr) && n < 64);
        if (n >= 64) n_errors++;
    endtask
    task automatic pkt(input bit rx, input int len, input bit flag, input logic [31:0] base);
        for (int i = 0; i < len; i++) put(rx, '{base + i, i == 0, i == len - 1, flag});
        @(negedge clk_i);
        utv = 1'b0;
        mrv = 1'b0;
    endtask
    task automatic expect_q(input bit rx, input int len, input bit flag, input bit one,
        input logic [31:0] base);
        beat_t b;
        for (int n = 0; n < 64 && (rx ? rq.size() : tq.size()) < len; n++) @(negedge clk_i);
        check(rx ? rq.size() : tq.size(), len);
        for (int i = 0; i < len; i++) begin
            b = rx ? rq.pop_front() : tq.pop_front();
            check(b, {base + i, one || i == 0, one || i == len - 1, flag});
        end
    endtask
    task automatic t_tx(input bit flag, input bit m, input bit t, input bit exp,
        input logic [31:0] base);
        @(negedge clk_i);
        mode = m;
        term = t;
        repeat (2) @(negedge clk_i);
        pkt(0, 3, flag, base);
        expect_q(0, 3, exp, 1'b0, base);
        if (exp) check(txs, sync_of(txc));
        $display("tx test done at %0t", $time);
    endtask
    task automatic t_rx(input bit flag, input bit pass, input logic [31:0] base);
        int d;
        d = drops;
        @(negedge clk_i);
        apv = !flag;
        ap = pass;
        fork
            pkt(1, 2, flag, base);
            if (flag) begin
                repeat (3) @(negedge clk_i);
                check(mrr, 1'b0);
                apv = 1'b1;
            end
        join
        if (flag && !pass) begin
            repeat (4) @(negedge clk_i);
            check(drops - d, 1);
            check(rq.size(), 0);
        end else expect_q(1, 2, flag, 1'b0, base);
        if (flag) check(rxs, sync_of(rxc));
        $display("rx test done at %0t", $time);
    endtask
    task automatic t_full();
        int acc;
        acc = 0;
        @(negedge clk_i);
        block = 1'b1;
        utv = 1'b1;
        for (int i = 0; i < 8; i++) begin
            utb = '{32'h20000000 + acc, 1'b1, 1'b1, 1'b0};
            @(posedge clk_i);
            if (utr) acc++;
            @(negedge clk_i);
        end
        check(acc, 4);
        utv = 1'b0;
        block = 1'b0;
        expect_q(0, 4, 1'b0, 1'b1, 32'h20000000);
        $display("fifo test done at %0t", $time);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        check(sub, 16'h0000);
        t_tx(1'b0, 1'b0, 1'b0, 1'b0, 32'h10000000);
        stall = 1'b1;
        t_tx(1'b1, 1'b0, 1'b0, 1'b1, 32'h11000000);
        t_tx(1'b0, 1'b1, 1'b1, 1'b1, 32'h12000000);
        t_tx(1'b0, 1'b1, 1'b0, 1'b0, 32'h13000000);
        t_rx(1'b0, 1'b1, 32'h30000000);
        stall = 1'b0;
        t_rx(1'b1, 1'b1, 32'h31000000);
        t_rx(1'b1, 1'b0, 32'h32000000);
        stall = 1'b1;
        t_full();
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
endmodule // tb_security_sublayer_encap
`default_nettype wire
